/* hdl/sfr_regs.sv */
// Purpose: Control and status register bank of the serial flash interface.
// Assumes: Wishbone classic single-cycle master; engine inputs on ref_clk.
// Notes:   One ack per request, one cycle after it is first seen.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns

module sfr_regs (
	// Clock and reset.
	input  wire logic                 ref_clk,
	input  wire logic                 reset_n,
	// Wishbone classic slave.
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// Serial engine side.
	input  wire sfr_pkg::sfr_engine_s engine,
	output sfr_pkg::sfr_ctrl_s        ctrl,
	output logic                      targetSelect,
	output logic                      txDmaReq,
	output logic                      rxDmaReq,
	output logic                      irq
);
	import sfr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Register state.

	typedef struct packed {
		sfr_bus_e          busState;
		logic [31:0]       rdata;
		sfr_ctrl_s         ctrl;
		logic              targetSel;
		logic [IRQ_W-1:0]  mask;
		logic [IRQ_W-1:0]  sticky;
		logic [1:0]        dmaOn;
		logic              txDma;
		logic              rxDma;
		logic              irq;
	} sfr_state_s;

	sfr_state_s state_r;
	sfr_state_s state_nxt;

	// Byte-lane merge for partial writes.
	function automatic logic [31:0] laneMerge(
		input logic [31:0] old,
		input logic [31:0] din,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = din[i*8 +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Combinational next state.

	logic [IRQ_W-1:0] rawNow;
	logic [IRQ_W-1:0] clearNow;
	logic [IRQ_W-1:0] setNow;
	logic [31:0]      rdVal;
	logic [31:0]      wrVal;
	logic             access;
	logic             doRead;
	logic             doWrite;

	always_comb begin
		state_nxt = state_r;
		clearNow = '0;
		setNow = '0;
		setNow[IRQ_TX_OVERFLOW]  = engine.txOverflowEvt;
		setNow[IRQ_RX_OVERFLOW]  = engine.rxOverflowEvt;
		setNow[IRQ_RX_UNDERFLOW] = engine.rxUnderflowEvt;
		setNow[IRQ_CONTENTION]   = engine.contentionEvt;
		// Threshold conditions are levels from the engine, not sticky.
		rawNow = state_r.sticky;
		rawNow[IRQ_TX_EMPTY] = engine.txEmptyLevel;
		rawNow[IRQ_RX_FULL]  = engine.rxFullLevel;
		access = wb_cyc_i && wb_stb_i && (state_r.busState == BUS_IDLE);
		doRead = access && !wb_we_i;
		doWrite = access && wb_we_i;
		rdVal = 32'h0000_0000;
		case (wb_adr_i)
			OFS_FRAME_COUNT: rdVal[15:0] = state_r.ctrl.frameCount;
			OFS_ENGINE_EN:   rdVal[0] = state_r.ctrl.engineOn;
			OFS_THREE_WIRE:  rdVal[2:0] = {state_r.ctrl.threeWireHandshake,
				state_r.ctrl.threeWireDirection,
				state_r.ctrl.threeWireXferMode};
			OFS_TARGET_SEL:  rdVal[0] = state_r.targetSel;
			OFS_CLK_DIV:     rdVal[15:0] = state_r.ctrl.serialClockDivisor;
			OFS_TX_THRESH:   rdVal[7:0] = state_r.ctrl.txThreshold;
			OFS_RX_THRESH:   rdVal[7:0] = state_r.ctrl.rxThreshold;
			OFS_TX_FILL:     rdVal[7:0] = engine.txFillCount;
			OFS_RX_FILL:     rdVal[7:0] = engine.rxFillCount;
			OFS_STATUS:      rdVal[6:0] = {engine.collisionError,
				engine.transmissionError,
				engine.rxQueueFull,
				engine.rxQueueNonempty,
				engine.txQueueEmpty,
				engine.txQueueHasSpace,
				engine.engineBusy};
			OFS_IRQ_MASK:    rdVal[IRQ_W-1:0] = state_r.mask;
			OFS_IRQ_MASKED:  rdVal[IRQ_W-1:0] = rawNow & state_r.mask;
			OFS_IRQ_RAW:     rdVal[IRQ_W-1:0] = rawNow;
			OFS_TXO_CLR: begin
				rdVal[0] = state_r.sticky[IRQ_TX_OVERFLOW];
				clearNow[IRQ_TX_OVERFLOW] = doRead;
			end
			OFS_RXO_CLR: begin
				rdVal[0] = state_r.sticky[IRQ_RX_OVERFLOW];
				clearNow[IRQ_RX_OVERFLOW] = doRead;
			end
			OFS_RXU_CLR: begin
				rdVal[0] = state_r.sticky[IRQ_RX_UNDERFLOW];
				clearNow[IRQ_RX_UNDERFLOW] = doRead;
			end
			OFS_CONT_CLR: begin
				rdVal[0] = state_r.sticky[IRQ_CONTENTION];
				clearNow[IRQ_CONTENTION] = doRead;
			end
			OFS_ALL_CLR: begin
				rdVal[0] = |state_r.sticky;
				clearNow = doRead ? state_r.sticky : '0;
			end
			OFS_DMA_CTRL:    rdVal[1:0] = state_r.dmaOn;
			default:         rdVal = 32'h0000_0000;
		endcase
		wrVal = laneMerge(rdVal, wb_dat_i, wb_sel_i);

		// Writes to read-only and clear registers fall to the default.
		if (doWrite) begin
			case (wb_adr_i)
				OFS_FRAME_COUNT: state_nxt.ctrl.frameCount = wrVal[15:0];
				OFS_ENGINE_EN:   state_nxt.ctrl.engineOn = wrVal[0];
				OFS_THREE_WIRE: begin
					state_nxt.ctrl.threeWireHandshake = wrVal[2];
					state_nxt.ctrl.threeWireDirection = wrVal[1];
					state_nxt.ctrl.threeWireXferMode  = wrVal[0];
				end
				OFS_TARGET_SEL:  state_nxt.targetSel = wrVal[0];
				OFS_CLK_DIV:     state_nxt.ctrl.serialClockDivisor = wrVal[15:0];
				OFS_TX_THRESH:   state_nxt.ctrl.txThreshold = wrVal[7:0];
				OFS_RX_THRESH:   state_nxt.ctrl.rxThreshold = wrVal[7:0];
				OFS_IRQ_MASK:    state_nxt.mask = wrVal[IRQ_W-1:0];
				OFS_DMA_CTRL:    state_nxt.dmaOn = wrVal[1:0];
				default:         state_nxt.dmaOn = state_r.dmaOn;
			endcase
		end

		// A new event in the clearing cycle survives: set wins over clear.
		state_nxt.sticky = (state_r.sticky & ~clearNow) | setNow;

		case (state_r.busState)
			BUS_IDLE: begin
				if (access) begin
					state_nxt.busState = BUS_ACK;
					state_nxt.rdata = rdVal;
				end
			end
			BUS_ACK: begin
				state_nxt.busState = BUS_IDLE;
				state_nxt.rdata = 32'h0000_0000;
			end
			default: state_nxt.busState = BUS_IDLE;
		endcase

		// Outputs are registered; they follow their sources one cycle late, save dmaOn, which the dma gates take from state_nxt in the same edge.
		state_nxt.txDma = engine.txDmaReq && state_nxt.dmaOn[DMA_TX_BIT];
		state_nxt.rxDma = engine.rxDmaReq && state_nxt.dmaOn[DMA_RX_BIT];
		state_nxt.irq = |(rawNow & state_r.mask);
	end

	////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r.busState <= BUS_IDLE;
			state_r.rdata <= 32'h0000_0000;
			state_r.ctrl <= '{frameCount: RST_FRAME_COUNT,
				engineOn: 1'b0,
				threeWireHandshake: RST_THREE_WIRE[2],
				threeWireDirection: RST_THREE_WIRE[1],
				threeWireXferMode: RST_THREE_WIRE[0],
				serialClockDivisor: RST_CLK_DIV,
				txThreshold: RST_THRESH,
				rxThreshold: RST_THRESH};
			state_r.targetSel <= 1'b0;
			state_r.mask <= RST_IRQ;
			state_r.sticky <= RST_IRQ;
			state_r.dmaOn <= RST_DMA;
			state_r.txDma <= 1'b0;
			state_r.rxDma <= 1'b0;
			state_r.irq <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign wb_ack_o = (state_r.busState == BUS_ACK);
	assign wb_dat_o = state_r.rdata;
	assign ctrl = state_r.ctrl;
	assign targetSelect = state_r.targetSel;
	assign txDmaReq = state_r.txDma;
	assign rxDmaReq = state_r.rxDma;
	assign irq = state_r.irq;

endmodule

/* hdl/sfr_pkg.sv */
// Purpose: Shared constants and carrier types for the serial flash register bank.
// Assumes: Wishbone classic slave with 32-bit data and byte addresses.
// Notes:   Every printed offset is a multiple of four, so offsets are byte addresses.
package sfr_pkg;

	localparam logic [7:0] OFS_FRAME_COUNT  = 8'h04;
	localparam logic [7:0] OFS_ENGINE_EN    = 8'h08;
	localparam logic [7:0] OFS_THREE_WIRE   = 8'h0c;
	localparam logic [7:0] OFS_TARGET_SEL   = 8'h10;
	localparam logic [7:0] OFS_CLK_DIV      = 8'h14;
	localparam logic [7:0] OFS_TX_THRESH    = 8'h18;
	localparam logic [7:0] OFS_RX_THRESH    = 8'h1c;
	localparam logic [7:0] OFS_TX_FILL      = 8'h20;
	localparam logic [7:0] OFS_RX_FILL      = 8'h24;
	localparam logic [7:0] OFS_STATUS       = 8'h28;
	localparam logic [7:0] OFS_IRQ_MASK     = 8'h2c;
	localparam logic [7:0] OFS_IRQ_MASKED   = 8'h30;
	localparam logic [7:0] OFS_IRQ_RAW      = 8'h34;
	localparam logic [7:0] OFS_TXO_CLR      = 8'h38;
	localparam logic [7:0] OFS_RXO_CLR      = 8'h3c;
	localparam logic [7:0] OFS_RXU_CLR      = 8'h40;
	localparam logic [7:0] OFS_CONT_CLR     = 8'h44;
	localparam logic [7:0] OFS_ALL_CLR      = 8'h48;
	localparam logic [7:0] OFS_DMA_CTRL     = 8'h4c;

	// Interrupt bit positions, shared by mask, masked and raw words.
	localparam int IRQ_TX_EMPTY    = 0;
	localparam int IRQ_TX_OVERFLOW = 1;
	localparam int IRQ_RX_UNDERFLOW = 2;
	localparam int IRQ_RX_OVERFLOW = 3;
	localparam int IRQ_RX_FULL     = 4;
	localparam int IRQ_CONTENTION  = 5;
	localparam int IRQ_W           = 6;

	localparam int DMA_RX_BIT = 0;
	localparam int DMA_TX_BIT = 1;

	localparam logic [15:0]       RST_FRAME_COUNT = 16'h0000;
	localparam logic [15:0]       RST_CLK_DIV     = 16'h0000;
	localparam logic [7:0]        RST_THRESH      = 8'h00;
	localparam logic [2:0]        RST_THREE_WIRE  = 3'h0;
	localparam logic [IRQ_W-1:0]  RST_IRQ         = 6'h00;
	localparam logic [1:0]        RST_DMA         = 2'h0;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} sfr_bus_e;

	// Live inputs from the serial engine and its queues.
	typedef struct packed {
		logic [7:0] txFillCount;
		logic [7:0] rxFillCount;
		logic       collisionError;
		logic       transmissionError;
		logic       rxQueueFull;
		logic       rxQueueNonempty;
		logic       txQueueEmpty;
		logic       txQueueHasSpace;
		logic       engineBusy;
		logic       txEmptyLevel;
		logic       rxFullLevel;
		logic       txOverflowEvt;
		logic       rxOverflowEvt;
		logic       rxUnderflowEvt;
		logic       contentionEvt;
		logic       txDmaReq;
		logic       rxDmaReq;
	} sfr_engine_s;

	// Control values handed to the serial engine.
	typedef struct packed {
		logic [15:0] frameCount;
		logic        engineOn;
		logic        threeWireHandshake;
		logic        threeWireDirection;
		logic        threeWireXferMode;
		logic [15:0] serialClockDivisor;
		logic [7:0]  txThreshold;
		logic [7:0]  rxThreshold;
	} sfr_ctrl_s;

endpackage

/* verif/sfr_regs_chk.sv */
// Purpose: Concurrent checks on the register bank ports.
// Assumes: The bus master holds its request through the ack edge.
// Notes:   Read data carries the state seen at the taking edge.
`timescale 1ns/1ns
module sfr_regs_chk (
	// Clock and reset.
	input wire logic                 ref_clk,
	input wire logic                 reset_n,
	// Bus.
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic                 wb_we_i,
	input wire logic [7:0]           wb_adr_i,
	input wire logic [3:0]           wb_sel_i,
	input wire logic [31:0]          wb_dat_i,
	input wire logic [31:0]          wb_dat_o,
	input wire logic                 wb_ack_o,
	// Engine side.
	input wire sfr_pkg::sfr_engine_s engine,
	input wire sfr_pkg::sfr_ctrl_s   ctrl,
	input wire logic                 targetSelect,
	input wire logic                 txDmaReq,
	input wire logic                 rxDmaReq,
	input wire logic                 irq
);
	import sfr_pkg::*;
	logic rdAck;
	assign rdAck = wb_ack_o && !wb_we_i;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	status_live_a: assert property (
		rdAck && wb_adr_i == OFS_STATUS
		|-> wb_dat_o == {25'h0, $past(engine[14:8])}) else $error("bad status");
	fill_live_a: assert property (
		rdAck && wb_adr_i == OFS_TX_FILL
		|-> wb_dat_o == {24'h0, $past(engine.txFillCount)}) else $error("bad fill");
	clear_word_a: assert property (
		rdAck && wb_adr_i >= OFS_TXO_CLR && wb_adr_i <= OFS_ALL_CLR
		|-> wb_dat_o[31:1] == 31'h0) else $error("clear word high bits set");
	frame_write_a: assert property (
		wb_ack_o && wb_we_i && wb_adr_i == OFS_FRAME_COUNT && wb_sel_i == 4'hf
		|=> ctrl.frameCount == $past(wb_dat_i[15:0])) else $error("bad frames");
	target_write_a: assert property (
		wb_ack_o && wb_we_i && wb_adr_i == OFS_TARGET_SEL && wb_sel_i[0]
		|=> targetSelect == $past(wb_dat_i[0])) else $error("bad select");
	dma_gate_a: assert property (txDmaReq |-> $past(engine.txDmaReq))
		else $error("tx dma request without engine request");
	irq_match_a: assert property (
		rdAck && wb_adr_i == OFS_IRQ_MASKED
		|-> irq == (wb_dat_o[5:0] != 6'h0)) else $error("irq disagrees");
endmodule
////////////////////////////////////////////////////////////////////////////
bind sfr_regs sfr_regs_chk u_chk (.ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .engine,
	.ctrl, .targetSelect, .txDmaReq, .rxDmaReq, .irq);

/* verif/sfr_regs_tb_top.sv */
// Purpose: Self-checking bench for the register bank.
// Assumes: One clock; a classic bus master lives in the tasks.
// Notes:   Read expectations queue up and are checked when ack comes.
`timescale 1ns/1ns
module sfr_regs_tb_top;
	import sfr_pkg::*;
	logic        ref_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic        targetSelect, txDmaReq, rxDmaReq, irq;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, d;
	sfr_engine_s engine;
	sfr_ctrl_s   ctrl;
	logic [31:0] expQ[$];
	int          seed, fail_count, n_checks, cycles;
	logic [7:0]  ofs[9] = '{OFS_FRAME_COUNT, OFS_ENGINE_EN, OFS_THREE_WIRE,
		OFS_TARGET_SEL, OFS_CLK_DIV, OFS_TX_THRESH, OFS_RX_THRESH,
		OFS_IRQ_MASK, OFS_DMA_CTRL};
	logic [31:0] msk[9] = '{32'hffff, 32'h1, 32'h7, 32'h1, 32'hffff,
		32'hff, 32'hff, 32'h3f, 32'h3};
	logic [7:0]  clr[4] = '{OFS_TXO_CLR, OFS_RXO_CLR, OFS_RXU_CLR, OFS_CONT_CLR};
	int          bitPos[4] = '{1, 3, 2, 5};
	sfr_regs u_dut (.ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .engine, .ctrl,
		.targetSelect, .txDmaReq, .rxDmaReq, .irq);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] dt, input logic [3:0] s);
		int n;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= dt;
		wb_sel_i <= s;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(1'b0, a, 32'h0, 4'hf);
	endtask
	task automatic pulse(input logic [3:0] evts);
		@(posedge ref_clk);
		engine[5:2] <= evts;
		@(posedge ref_clk);
		engine[5:2] <= 4'h0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// The request is still held at the ack edge, so we tells reads apart.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (wb_ack_o === 1'b1 && !wb_we_i && expQ.size() > 0)
			chk(wb_dat_o, expQ.pop_front());
		if (cycles > 5000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		seed = 32'h6351;
		{wb_cyc_i, wb_stb_i, wb_we_i, reset_n} = 4'h0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		engine = '0;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int a = 0; a < 8'h54; a += 4)
			rd(8'(a), 32'h0);
		for (int i = 0; i < 9; i++) begin
			d = $random(seed);
			bus(1'b1, ofs[i], d, 4'hf);
			rd(ofs[i], d & msk[i]);
		end
		bus(1'b1, OFS_FRAME_COUNT, 32'hffff, 4'hf);
		bus(1'b1, OFS_FRAME_COUNT, 32'h0, 4'h2);
		rd(OFS_FRAME_COUNT, 32'hff);
		chk(32'(ctrl.frameCount), 32'hff);
		bus(1'b1, OFS_RX_THRESH, 32'h1a5, 4'hf);
		rd(OFS_RX_THRESH, 32'ha5);
		chk(32'(ctrl.rxThreshold), 32'ha5);
		bus(1'b1, OFS_TARGET_SEL, 32'h1, 4'hf);
		chk(32'(targetSelect), 32'h1);
		bus(1'b1, OFS_TARGET_SEL, 32'h0, 4'hf);
		chk(32'(targetSelect), 32'h0);
		// Status and fill levels only; threshold levels, events and dma requests stay quiet here.
		d = $random(seed);
		engine <= sfr_engine_s'(d[30:0] & 31'h7fffff00);
		bus(1'b1, OFS_STATUS, 32'hffffffff, 4'hf);
		rd(OFS_STATUS, {25'h0, engine[14:8]});
		rd(OFS_RX_FILL, {24'h0, engine.rxFillCount});
		engine <= '0;
		bus(1'b1, OFS_IRQ_MASK, 32'h3f, 4'hf);
		for (int i = 0; i < 4; i++) begin
			pulse(4'h8 >> i);
			rd(OFS_IRQ_RAW, 32'h1 << bitPos[i]);
			chk(32'(irq), 32'h1);
			rd(clr[i], 32'h1);
			rd(OFS_IRQ_MASKED, 32'h0);
			chk(32'(irq), 32'h0);
		end
		rd(OFS_TXO_CLR, 32'h0);
		rd(OFS_RXO_CLR, 32'h0);
		rd(OFS_RXU_CLR, 32'h0);
		rd(OFS_CONT_CLR, 32'h0);
		pulse(4'hf);
		rd(OFS_IRQ_MASKED, 32'h2e);
		rd(OFS_ALL_CLR, 32'h1);
		rd(OFS_ALL_CLR, 32'h0);
		bus(1'b1, OFS_IRQ_MASK, 32'h10, 4'hf);
		engine[7:6] <= 2'b10;
		rd(OFS_IRQ_RAW, 32'h1);
		rd(OFS_IRQ_MASKED, 32'h0);
		engine[7:6] <= 2'b01;
		rd(OFS_IRQ_MASKED, 32'h10);
		engine[1:0] <= 2'b11;
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, OFS_DMA_CTRL, 32'(i), 4'hf);
			repeat (2) @(posedge ref_clk);
			chk(32'({txDmaReq, rxDmaReq}), 32'(i));
		end
		repeat (3) @(posedge ref_clk);
		chk(32'(expQ.size()), 32'h0);
		report_and_stop();
	end
endmodule
